// ### shared/fsm_pkg.sv
`default_nettype none
package fsm_pkg;

  typedef enum logic [1:0] {
    FSM_INIT,
    FSM_PREOP,
    FSM_SAFEOP,
    FSM_OP
  } fsm_state_t;

  localparam int unsigned FSM_STATE_W   = 2;
  localparam logic [1:0]  FSM_RESET_ST  = 2'h0;
  localparam int unsigned FSM_VAR_MAPS  = 1;
  localparam int unsigned FSM_FIX_MAPS  = 6;
  localparam int unsigned FSM_MAP_SEL_W = 3;
  localparam logic [2:0]  FSM_MAP_VAR   = 3'h0;
  localparam logic [2:0]  FSM_MAP_LAST  = 3'h6;

endpackage : fsm_pkg
`default_nettype wire

// ### design/fsm_sync.sv
`timescale 1ns/10ps
`default_nettype none
module fsm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // Two-stage synchroniser; the first stage feeds only the second.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else if (clk_en_in) begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule // fsm_sync
`default_nettype wire

// ### design/fsm_fieldbus_state_machine.sv
`timescale 1ns/10ps
`default_nettype none
module fsm_fieldbus_state_machine
  import fsm_pkg::*;
#(
  parameter int unsigned FIX_MAPS = FSM_FIX_MAPS
) (
  input  wire logic                           sys_clk_in,
  input  wire logic                           arst_n_in,
  input  wire logic                           clk_en_in,
  input  wire logic                           req_valid_in,
  input  wire fsm_pkg::fsm_state_t            req_state_in,
  input  wire logic                           prep_done_in,
  input  wire logic                           cycle_tick_in,
  input  wire logic                           sdo_req_in,
  input  wire logic [fsm_pkg::FSM_MAP_SEL_W-1:0] rpdo_map_sel_in,
  input  wire logic [fsm_pkg::FSM_MAP_SEL_W-1:0] tpdo_map_sel_in,
  output fsm_pkg::fsm_state_t                 state_out,
  output logic                                sdo_enable_out,
  output logic                                sdo_grant_out,
  output logic                                tpdo_strobe_out,
  output logic                                rpdo_strobe_out,
  output logic                                outputs_valid_out,
  output logic                                refused_out,
  output logic                                map_err_out
);

  import fsm_pkg::*;

  fsm_state_t state_ff;
  fsm_state_t nxt_state;
  logic       nxt_refused;
  logic       prep_sync;
  logic       sdo_allow;
  logic       tpdo_allow;
  logic       rpdo_allow;
  logic       map_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // The preparation flag comes from the master side and is synchronised.

  fsm_sync #(
    .WIDTH(1)
  ) u_prep_sync (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .clk_en_in  (clk_en_in),
    .async_in   (prep_done_in),
    .sync_out   (prep_sync)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Transition decision.

  always_comb begin
    nxt_state   = state_ff;
    nxt_refused = 1'b0;
    if (req_valid_in) begin
      if (req_state_in < state_ff) begin
        nxt_state = req_state_in;
      end else if (req_state_in == state_ff) begin
        nxt_state = state_ff;
      end else if ((req_state_in == fsm_state_t'(state_ff + 2'h1)) && prep_sync) begin
        nxt_state = req_state_in;
      end else begin
        nxt_refused = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff <= fsm_state_t'(FSM_RESET_ST);
    end else if (clk_en_in) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      refused_out <= 1'b0;
    end else if (clk_en_in) begin
      refused_out <= nxt_refused;
    end
  end

  assign state_out = state_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Service gating per state.

  always_comb begin
    sdo_allow  = 1'b0;
    tpdo_allow = 1'b0;
    rpdo_allow = 1'b0;
    case (state_ff)
      FSM_INIT: begin
        sdo_allow = 1'b0;
      end
      FSM_PREOP: begin
        sdo_allow = 1'b1;
      end
      FSM_SAFEOP: begin
        sdo_allow  = 1'b1;
        tpdo_allow = 1'b1;
      end
      FSM_OP: begin
        sdo_allow  = 1'b1;
        tpdo_allow = 1'b1;
        rpdo_allow = 1'b1;
      end
      default: begin
        sdo_allow = 1'b0;
      end
    endcase
  end

  // Selector 0 is the variable mapping, 1..FIX_MAPS the fixed ones.
  assign map_ok = (rpdo_map_sel_in <= FSM_MAP_SEL_W'(FIX_MAPS)) &&
                  (tpdo_map_sel_in <= FSM_MAP_SEL_W'(FIX_MAPS));

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sdo_enable_out    <= 1'b0;
      outputs_valid_out <= 1'b0;
      map_err_out       <= 1'b0;
    end else if (clk_en_in) begin
      sdo_enable_out    <= sdo_allow;
      outputs_valid_out <= rpdo_allow && map_ok;
      map_err_out       <= !map_ok;
    end
  end

  // Process data moves once per cycle tick; SDO is answered on demand.
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tpdo_strobe_out <= 1'b0;
      rpdo_strobe_out <= 1'b0;
      sdo_grant_out   <= 1'b0;
    end else if (clk_en_in) begin
      tpdo_strobe_out <= cycle_tick_in && tpdo_allow && map_ok;
      rpdo_strobe_out <= cycle_tick_in && rpdo_allow && map_ok;
      sdo_grant_out   <= sdo_req_in && sdo_allow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence skip_req_s;
    clk_en_in && req_valid_in && (req_state_in > state_ff) &&
      (req_state_in != fsm_state_t'(state_ff + 2'h1));
  endsequence

  skip_refused_a: assert property (skip_req_s |=> $stable(state_ff) && refused_out)
    else $error("Skipping upward request was honoured.");

  down_jump_a: assert property (clk_en_in && req_valid_in && req_state_in < state_ff
    |=> state_ff == $past(req_state_in))
    else $error("Downward request not taken.");

  init_quiet_a: assert property (state_ff == FSM_INIT && clk_en_in
    |=> !sdo_grant_out && !tpdo_strobe_out && !rpdo_strobe_out)
    else $error("Traffic in init state.");

  preop_sdo_a: assert property (state_ff == FSM_PREOP && clk_en_in
    |=> !tpdo_strobe_out && !rpdo_strobe_out)
    else $error("Process data in preop state.");

  safeop_out_a: assert property (state_ff == FSM_SAFEOP && clk_en_in
    |=> !rpdo_strobe_out && !outputs_valid_out)
    else $error("Outputs driven in safeop state.");

  op_rpdo_a: assert property (state_ff == FSM_OP && clk_en_in && cycle_tick_in && map_ok
    |=> rpdo_strobe_out && tpdo_strobe_out)
    else $error("Process data missing in op state.");

  sdo_ack_a: assert property (clk_en_in && sdo_req_in && state_ff != FSM_INIT
    |=> sdo_grant_out)
    else $error("SDO not granted.");

  map_range_a: assert property (clk_en_in && !map_ok |=> map_err_out && !outputs_valid_out)
    else $error("Bad mapping not flagged.");

  step_up_a: assert property (clk_en_in && req_valid_in && prep_sync &&
    req_state_in == fsm_state_t'(state_ff + 2'h1) && state_ff != FSM_OP
    |=> state_ff == $past(req_state_in))
    else $error("Single step up not taken.");

endmodule // fsm_fieldbus_state_machine
`default_nettype wire

// ### tb/fsm_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module fsm_master_model (
  input  wire logic          sys_clk_in,
  output fsm_pkg::fsm_state_t req_state_out,
  output logic               req_valid_out,
  output logic               prep_done_out
);
  import fsm_pkg::*;

  initial begin
    req_valid_out = 1'h0;
    req_state_out = FSM_INIT;
    prep_done_out = 1'h0;
  end

  // The preparation flag settles before a request is raised.
  task automatic request(input fsm_state_t st, input logic prep);
    prep_done_out <= prep;
    repeat (3) @(negedge sys_clk_in);
    req_valid_out <= 1'h1;
    req_state_out <= st;
    @(negedge sys_clk_in);
    req_valid_out <= 1'h0;
    req_state_out <= fsm_state_t'(~st);
  endtask
endmodule // fsm_master_model
`default_nettype wire

// ### tb/fsm_fieldbus_state_machine_test.sv
`timescale 1ns/10ps
`default_nettype none
module fsm_fieldbus_state_machine_test;
  import fsm_pkg::*;
  logic       sys_clk_in = 1'h0;
  logic       arst_n_in  = 1'h0;
  logic       tick       = 1'h0;
  logic       sdo        = 1'h0;
  logic       en         = 1'h1;
  logic [2:0] sel        = 3'h0;
  fsm_state_t req_state, state;
  logic       req_valid, prep, sdo_en, grant, tstb, rstb, ov, refused, merr;
  int         n_fail      = 0;
  int         check_count = 0;

  always #10 sys_clk_in = ~sys_clk_in;

  fsm_master_model i_master (.sys_clk_in(sys_clk_in), .req_state_out(req_state),
    .req_valid_out(req_valid), .prep_done_out(prep));

  fsm_fieldbus_state_machine i_dut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .clk_en_in(en), .req_valid_in(req_valid), .req_state_in(req_state),
    .prep_done_in(prep), .cycle_tick_in(tick), .sdo_req_in(sdo),
    .rpdo_map_sel_in(sel), .tpdo_map_sel_in(sel), .state_out(state),
    .sdo_enable_out(sdo_en), .sdo_grant_out(grant), .tpdo_strobe_out(tstb),
    .rpdo_strobe_out(rstb), .outputs_valid_out(ov), .refused_out(refused),
    .map_err_out(merr));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Requests a state and checks the answer one cycle later.
  task automatic move(input fsm_state_t st, input logic prep, input fsm_state_t xs,
                      input logic xr);
    i_master.request(st, prep);
    chk("state", state, xs);
    chk("refused", refused, xr);
    @(negedge sys_clk_in);
  endtask

  // Requests a state from preop while the clock enable is low; nothing may move.
  task automatic frozen(input fsm_state_t st);
    en <= 1'h0;
    i_master.request(st, 1'h1);
    chk("state_frozen", state, FSM_PREOP);
    chk("refused_frozen", refused, 1'h0);
    en <= 1'h1;
    @(negedge sys_clk_in);
  endtask

  // Pulls reset in mid-run; state, sdo_enable and refused must be back at reset one cycle later.
  task automatic reset_mid;
    arst_n_in <= 1'h0;
    @(negedge sys_clk_in);
    chk("state_rst", state, FSM_INIT);
    chk("sdo_enable_rst", sdo_en, 1'h0);
    chk("refused_rst", refused, 1'h0);
    arst_n_in <= 1'h1;
    @(negedge sys_clk_in);
    chk("state_rel", state, FSM_INIT);
  endtask

  // Sends one cycle tick and one mailbox request, then checks the answers.
  task automatic traffic(input logic xe, input logic xg, input logic xt, input logic xr,
                         input logic xv);
    tick <= 1'h1;
    sdo <= 1'h1;
    @(negedge sys_clk_in);
    tick <= 1'h0;
    sdo <= 1'h0;
    chk("sdo_enable", sdo_en, xe);
    chk("sdo_grant", grant, xg);
    chk("tpdo_strobe", tstb, xt);
    chk("rpdo_strobe", rstb, xr);
    chk("outputs_valid", ov, xv);
  endtask

  // Walks every mapping selector in the operational state.
  task automatic maps;
    for (int i = 0; i < 8; i++) begin
      sel <= i[2:0];
      repeat (3) @(negedge sys_clk_in);
      chk("map_err", merr, {3'h0, i == 7});
      traffic(1'h1, 1'h1, i != 7, i != 7, i != 7);
    end
    sel <= 3'h0;
    repeat (3) @(negedge sys_clk_in);
  endtask

  initial begin
    repeat (4) @(negedge sys_clk_in);
    arst_n_in <= 1'h1;
    chk("state", state, FSM_INIT);
    traffic(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    move(FSM_OP, 1'h1, FSM_INIT, 1'h1);
    move(FSM_PREOP, 1'h0, FSM_INIT, 1'h1);
    move(FSM_PREOP, 1'h1, FSM_PREOP, 1'h0);
    traffic(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
    frozen(FSM_SAFEOP);
    frozen(FSM_OP);
    move(FSM_PREOP, 1'h1, FSM_PREOP, 1'h0);
    move(FSM_OP, 1'h1, FSM_PREOP, 1'h1);
    move(FSM_SAFEOP, 1'h1, FSM_SAFEOP, 1'h0);
    traffic(1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    move(FSM_OP, 1'h1, FSM_OP, 1'h0);
    traffic(1'h1, 1'h1, 1'h1, 1'h1, 1'h1);
    maps();
    move(FSM_PREOP, 1'h0, FSM_PREOP, 1'h0);
    traffic(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
    reset_mid();
    move(FSM_PREOP, 1'h1, FSM_PREOP, 1'h0);
    move(FSM_INIT, 1'h0, FSM_INIT, 1'h0);
    traffic(1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    print_verdict();
  end
endmodule // fsm_fieldbus_state_machine_test
`default_nettype wire
